// ### hw/bmg_pkg.sv
// Shared constants for the board memory glue logic and its controller
package bmg_pkg;
   // -----------------------------------------------------------------
   // Chip-select numbering
   // -----------------------------------------------------------------
   localparam int CS_WIDTH = 8;
   localparam int CS_FLASH = 0;
   localparam int CS_CTRL = 1;
   localparam int CS_DRAM1 = 2;
   localparam int CS_DRAM2 = 3;
   localparam int CS_SDRAM = 4;

   // -----------------------------------------------------------------
   // board_control_reg_one fields and power-on value
   // -----------------------------------------------------------------
   localparam int CTL_FLASH_DIS = 0;
   localparam int CTL_CTRL_DIS = 1;
   localparam int CTL_DRAM_DIS = 2;
   localparam int CTL_SDRAM_EN = 3;
   localparam int CTL_HALF_WORD = 4;
   localparam int CTL_WIDTH = 5;
   localparam logic [4:0] CTL_RESET = 5'h08;

   // -----------------------------------------------------------------
   // board_status_reg_two fields
   // -----------------------------------------------------------------
   localparam int STS_SIZE_LSB = 0;
   localparam int STS_SIZE_W = 3;
   localparam int STS_DELAY = 3;

   // -----------------------------------------------------------------
   // Local register offsets inside the control block select region
   // -----------------------------------------------------------------
   localparam logic [1:0] LOC_CTRL = 2'h1;
   localparam logic [1:0] LOC_STATUS = 2'h2;

   // -----------------------------------------------------------------
   // Clock mode pin codes
   // -----------------------------------------------------------------
   localparam logic [1:0] CLOCK_MODE_PINS_FAST = 2'h3;
   localparam logic [1:0] CLOCK_MODE_PINS_SLOW = 2'h0;
   // Edges counted after reset before the mode pin is taken
   localparam logic [1:0] MODE_SETTLE = 2'h2;

   // -----------------------------------------------------------------
   // APB offsets of the controller registers
   // -----------------------------------------------------------------
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_WDATA = 8'h04;
   localparam logic [7:0] APB_RDATA = 8'h08;
   localparam logic [7:0] APB_STAT = 8'h0C;
   localparam logic [7:0] APB_CS_PAT = 8'h10;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_CFG = 2;
   localparam int CMD_LOC_LSB = 4;
endpackage

// ### hw/bmg_bus_if.sv
// Local bus between processor memory controller and board glue logic
`timescale 1ns/1ps
interface bmg_bus_if;
   logic [7:0] cs_n;
   logic [1:0] loc_addr;
   logic rd_wr_n;
   logic cfg_phase;
   logic [7:0] data_to_board;
   logic [7:0] data_to_proc;
   logic data_to_proc_oe;
   logic xcvr_open;
   logic [1:0] clock_mode_pins;
   logic external_clock_input;
   logic [1:0] dram_bank1_select_n;
   logic [1:0] dram_bank2_select_n;
   logic [1:0] dram_addr_sel;

   modport board (
      input cs_n, loc_addr, rd_wr_n, cfg_phase, data_to_board,
      output data_to_proc, data_to_proc_oe, xcvr_open, clock_mode_pins,
      external_clock_input, dram_bank1_select_n, dram_bank2_select_n,
      dram_addr_sel
   );
   modport proc (
      output cs_n, loc_addr, rd_wr_n, cfg_phase, data_to_board,
      input data_to_proc, data_to_proc_oe, xcvr_open, clock_mode_pins,
      external_clock_input, dram_bank1_select_n, dram_bank2_select_n,
      dram_addr_sel
   );
endinterface

// ### hw/bmg_board.sv
// Board glue: transceiver gating, select fan-out, control and status
`timescale 1ns/1ps
// Behaviour
// - Transceivers open for enabled regions or config
// - Disabled region keeps transceivers closed
// - SDRAM accesses never open transceivers
// - Selects: flash, control, dram1, dram2, sdram
// - Control bit disables each on-board memory
// - Removed control block stays gone until power
// - DRAM enable bit acts at any time
// - Status register reports DRAM size and delay
// - Timing machine A drives DRAM strobes
// - Each DRAM select split into two copies
// - 16-bit DRAM uses upper data lanes only
// - Set half-word bit before port size
// - Bank-0 mask half or quarter size
// - Second bank base at quarter volume
// - Reconfiguring code must not run from DRAM
// - Slow clock mode holds external clock low
// - Logic clock is processor/debug clock mux
// - Clock-mode pins 11 or 00 at power-on
// - Half-word bit switches two DRAM address lines
module bmg_board (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic power_on_n,
   input wire logic slow_clock_mode,
   input wire logic oscillator_clock_input,
   input wire logic [2:0] dram_size_code,
   input wire logic dram_delay_70,
   output logic [4:0] control_bits,
   bmg_bus_if.board bus
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0] cs_s1_reg, cs_s2_reg;
   logic cfg_s1_reg, cfg_s2_reg;
   logic mode_s1_reg, mode_s2_reg;
   logic [2:0] size_s1_reg, size_s2_reg;
   logic delay_s1_reg, delay_s2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_s1_reg <= 8'hFF;
         cs_s2_reg <= 8'hFF;
         cfg_s1_reg <= 1'b0;
         cfg_s2_reg <= 1'b0;
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= bus.cs_n;
         cs_s2_reg <= cs_s1_reg;
         cfg_s1_reg <= bus.cfg_phase;
         cfg_s2_reg <= cfg_s1_reg;
         mode_s1_reg <= slow_clock_mode;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   // Straps are board pins too, so they are synchronised as well
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_s1_reg <= 3'h0;
         size_s2_reg <= 3'h0;
         delay_s1_reg <= 1'b0;
         delay_s2_reg <= 1'b0;
      end else begin
         size_s1_reg <= dram_size_code;
         size_s2_reg <= size_s1_reg;
         delay_s1_reg <= dram_delay_70;
         delay_s2_reg <= delay_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Control register and removal latch
   // ----------------------------------------------------------------
   // Power domain reset: presetn only follows hard reset, power_on_n
   // clears the control block on power application.
   logic [4:0] ctl_reg, ctl_next;
   logic ctrl_gone_reg;
   logic cs_prev_reg;
   wire ctl_cs = !cs_s2_reg[bmg_pkg::CS_CTRL] && !ctrl_gone_reg;
   wire ctl_strobe = ctl_cs && cs_prev_reg;
   wire ctl_wr = ctl_strobe && !bus.rd_wr_n
      && bus.loc_addr == bmg_pkg::LOC_CTRL;
   // write applies at once, no reset needed
   always_comb begin
      ctl_next = ctl_reg;
      if (ctl_wr)
         ctl_next = bus.data_to_board[4:0];
   end
   // removal latch cleared only by power
   always_ff @(posedge pclk or negedge power_on_n) begin
      if (!power_on_n) begin
         ctl_reg <= bmg_pkg::CTL_RESET;
         ctrl_gone_reg <= 1'b0;
         cs_prev_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         cs_prev_reg <= !cs_s2_reg[bmg_pkg::CS_CTRL] && !ctrl_gone_reg
            && !ctl_strobe;
         if (ctl_reg[bmg_pkg::CTL_CTRL_DIS])
            ctrl_gone_reg <= 1'b1;
      end
   end
   assign control_bits = ctl_reg;

   // ----------------------------------------------------------------
   // Region decode
   // ----------------------------------------------------------------
   // per-select enable
   wire flash_ok = !cs_s2_reg[bmg_pkg::CS_FLASH]
      && !ctl_reg[bmg_pkg::CTL_FLASH_DIS];
   wire dram_ok = (!cs_s2_reg[bmg_pkg::CS_DRAM1]
      || !cs_s2_reg[bmg_pkg::CS_DRAM2])
      && !ctl_reg[bmg_pkg::CTL_DRAM_DIS];
   wire open_next = flash_ok || dram_ok || ctl_cs || cfg_s2_reg;

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   logic xcvr_reg;
   logic [7:0] rdata_reg;
   logic rd_oe_reg;
   logic [1:0] d1_reg, d2_reg;
   logic [1:0] addr_sel_reg;
   logic [1:0] clock_mode_pins_reg;
   logic [1:0] settle_reg;
   wire [7:0] status_word = {4'h0, delay_s2_reg, size_s2_reg};
   wire [7:0] ctl_word = {3'h0, ctl_reg};
   wire rd_hit = ctl_cs && bus.rd_wr_n;
   wire [7:0] rd_sel = bus.loc_addr == bmg_pkg::LOC_STATUS ? status_word
      : ctl_word;

   // ----------------------------------------------------------------
   // Transceiver gate and read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xcvr_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rd_oe_reg <= 1'b0;
      end else begin
         xcvr_reg <= open_next;
         // status read shows size and delay
         rdata_reg <= rd_sel;
         rd_oe_reg <= rd_hit;
      end
   end

   // ----------------------------------------------------------------
   // DRAM bank select copies
   // ----------------------------------------------------------------
   // A disabled DRAM module keeps both copies of each bank select high
   wire dram_off = ctl_reg[bmg_pkg::CTL_DRAM_DIS];
   wire bank1_n = cs_s2_reg[bmg_pkg::CS_DRAM1] || dram_off;
   wire bank2_n = cs_s2_reg[bmg_pkg::CS_DRAM2] || dram_off;
   wire [1:0] bank1_copies_n, bank2_copies_n;
   // two copies of each bank select
   for (genvar i = 0; i < 2; i++) begin : g_copy
      assign bank1_copies_n[i] = bank1_n;
      assign bank2_copies_n[i] = bank2_n;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d1_reg <= 2'h3;
         d2_reg <= 2'h3;
      end else begin
         d1_reg <= bank1_copies_n;
         d2_reg <= bank2_copies_n;
      end
   end

   // ----------------------------------------------------------------
   // DRAM address routing
   // ----------------------------------------------------------------
   // Held with the control register, so a hard reset keeps the routing
   wire half_word = ctl_reg[bmg_pkg::CTL_HALF_WORD];
   always_ff @(posedge pclk or negedge power_on_n) begin
      if (!power_on_n)
         addr_sel_reg <= {2{bmg_pkg::CTL_RESET[bmg_pkg::CTL_HALF_WORD]}};
      else
         addr_sel_reg <= {2{half_word}};
   end

   // ----------------------------------------------------------------
   // Clock mode pins
   // ----------------------------------------------------------------
   // The mode pin is taken only once both synchroniser stages hold it
   wire mode_wait = settle_reg < bmg_pkg::MODE_SETTLE;
   wire mode_take = settle_reg == bmg_pkg::MODE_SETTLE;
   wire [1:0] mode_code = mode_s2_reg ? bmg_pkg::CLOCK_MODE_PINS_SLOW
      : bmg_pkg::CLOCK_MODE_PINS_FAST;
   // fast code until the mode pin is caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_reg <= 2'h0;
         clock_mode_pins_reg <= bmg_pkg::CLOCK_MODE_PINS_FAST;
      end else begin
         if (mode_wait || mode_take)
            settle_reg <= settle_reg + 2'h1;
         if (mode_take)
            clock_mode_pins_reg <= mode_code;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign bus.xcvr_open = xcvr_reg;
   assign bus.data_to_proc = rdata_reg;
   assign bus.data_to_proc_oe = rd_oe_reg;
   assign bus.dram_bank1_select_n = d1_reg;
   assign bus.dram_bank2_select_n = d2_reg;
   assign bus.dram_addr_sel = addr_sel_reg;
   assign bus.clock_mode_pins = clock_mode_pins_reg;
   // slow mode gates oscillator off, pin held low
   // pclk is the muxed processor/debug clock
   assign bus.external_clock_input = oscillator_clock_input
      && !mode_s2_reg;
endmodule

// ### hw/bmg_proc.sv
// Processor-side end: APB-controlled local bus access sequencer
`timescale 1ns/1ps
module bmg_proc (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   bmg_bus_if.proc bus
);
   typedef enum {BMGP_IDLE, BMGP_SEL, BMGP_HOLD, BMGP_DONE} bmgp_state_e;
   bmgp_state_e state_reg;
   logic [7:0] cmd_reg, wdata_reg, rdata_reg, pat_reg;
   logic busy_reg;
   logic [1:0] cnt_reg;
   wire wr_en = psel && penable && pwrite;
   wire hit_cmd = paddr == bmg_pkg::APB_CMD;
   wire hit_wd = paddr == bmg_pkg::APB_WDATA;
   wire hit_rd = paddr == bmg_pkg::APB_RDATA;
   wire hit_st = paddr == bmg_pkg::APB_STAT;
   wire hit_pat = paddr == bmg_pkg::APB_CS_PAT;
   wire mapped = hit_cmd || hit_wd || hit_rd || hit_st || hit_pat;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_cmd)
         prdata = {24'h0, cmd_reg};
      else if (hit_wd)
         prdata = {24'h0, wdata_reg};
      else if (hit_rd)
         prdata = {24'h0, rdata_reg};
      else if (hit_st)
         prdata = {31'h0, busy_reg};
      else if (hit_pat)
         prdata = {24'h0, pat_reg};
   end
   // ----------------------------------------------------------------
   // Register writes and bus sequencer
   // ----------------------------------------------------------------
   // software sequencing lives above
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg <= 8'h00;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         pat_reg <= 8'hFF;
         busy_reg <= 1'b0;
         cnt_reg <= 2'h0;
         state_reg <= BMGP_IDLE;
      end else begin
         if (wr_en && hit_wd)
            wdata_reg <= pwdata[7:0];
         if (wr_en && hit_pat)
            pat_reg <= pwdata[7:0];
         if (wr_en && hit_cmd && !busy_reg)
            cmd_reg <= pwdata[7:0];
         case (state_reg)
            BMGP_IDLE: begin
               if (wr_en && hit_cmd && !busy_reg
                  && pwdata[bmg_pkg::CMD_GO]) begin
                  busy_reg <= 1'b1;
                  state_reg <= BMGP_SEL;
                  cnt_reg <= 2'h0;
               end
            end
            BMGP_SEL: begin
               state_reg <= BMGP_HOLD;
            end
            BMGP_HOLD: begin
               // Select held five cycles (one in SEL, four in HOLD) to cover the board synchroniser
               cnt_reg <= cnt_reg + 2'h1;
               if (cnt_reg == 2'h3) begin
                  rdata_reg <= bus.data_to_proc;
                  state_reg <= BMGP_DONE;
               end
            end
            BMGP_DONE: begin
               busy_reg <= 1'b0;
               state_reg <= BMGP_IDLE;
            end
            default: state_reg <= BMGP_IDLE;
         endcase
      end
   end
   wire active = state_reg == BMGP_SEL || state_reg == BMGP_HOLD;
   // select pattern driven only during access
   assign bus.cs_n = active && !cmd_reg[bmg_pkg::CMD_CFG] ? pat_reg
      : 8'hFF;
   assign bus.cfg_phase = active && cmd_reg[bmg_pkg::CMD_CFG];
   assign bus.rd_wr_n = !cmd_reg[bmg_pkg::CMD_WRITE];
   assign bus.loc_addr = cmd_reg[bmg_pkg::CMD_LOC_LSB +: 2];
   assign bus.data_to_board = wdata_reg;
endmodule

// ### sim/bmg_checker.sv
// Concurrent checks on the local bus between the two ends
`timescale 1ns/1ps
module bmg_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic power_on_n,
   input wire logic [4:0] control_bits,
   input wire logic [7:0] cs_n,
   input wire logic cfg_phase,
   input wire logic xcvr_open,
   input wire logic [1:0] clock_mode_pins,
   input wire logic external_clock_input,
   input wire logic [1:0] dram_bank1_select_n,
   input wire logic [1:0] dram_bank2_select_n,
   input wire logic [1:0] dram_addr_sel
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Select pattern held for a whole access
   sequence held(p);
      (p) [*5];
   endsequence
   // Same level on four edges in a row, the depth of the select path
   sequence steady(s);
      $stable(s) && $past(s) == $past(s, 2) && $past(s, 2) == $past(s, 3);
   endsequence
   flash_open_a: assert property (
      held(cs_n == 8'hFE && !control_bits[0] && !cfg_phase) |-> xcvr_open)
      else $error("enabled flash access left transceivers closed");
   cfg_open_a: assert property (held(cfg_phase) |-> xcvr_open)
      else $error("config phase left transceivers closed");
   idle_closed_a: assert property (
      held(cs_n == 8'hFF && !cfg_phase) |-> !xcvr_open)
      else $error("transceivers open with no select");
   flash_off_a: assert property (
      held(cs_n == 8'hFE && control_bits[0] && !cfg_phase) |-> !xcvr_open)
      else $error("disabled flash opened transceivers");
   sdram_closed_a: assert property (
      held(cs_n == 8'hEF && !cfg_phase) |-> !xcvr_open)
      else $error("sdram access opened transceivers");
   removed_closed_a: assert property (
      held(cs_n == 8'hFD && control_bits[1]) |-> !xcvr_open)
      else $error("removed control block opened transceivers");
   removal_kept_a: assert property (disable iff (!power_on_n)
      control_bits[1] |=> control_bits[1])
      else $error("control block removal was undone");
   select_split_a: assert property (
      steady(cs_n[2]) |-> dram_bank1_select_n
         == {2{cs_n[2] || $past(control_bits[2])}})
      else $error("dram bank one copies differ from select");
   bank_two_split_a: assert property (
      steady(cs_n[3]) |-> dram_bank2_select_n
         == {2{cs_n[3] || $past(control_bits[2])}})
      else $error("dram bank two copies differ from select");
   slow_gate_a: assert property (
      clock_mode_pins == 2'h0 |-> !external_clock_input)
      else $error("external clock not held low in slow mode");
   mode_code_a: assert property (clock_mode_pins inside {2'h0, 2'h3})
      else $error("illegal clock mode code");
   width_mux_a: assert property (
      $stable(control_bits) |-> dram_addr_sel == {2{control_bits[4]}})
      else $error("address routing does not follow width bit");
endmodule

// ### sim/board_memory_glue_logic_tb.sv
// Testbench driving the controller over APB against the board end
`timescale 1ns/1ps
module board_memory_glue_logic_tb;
   logic pclk = 0, presetn = 0, power_on_n = 0, slow_mode = 0, osc = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, opened;
   logic drove;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [4:0] control_bits;
   logic [7:0] t_ctl [8] = '{8'h14, 8'h08, 8'h08, 8'h08, 8'h09, 8'h08,
      8'h08, 8'h08};
   logic [7:0] t_cs [8] = '{8'hFB, 8'hFB, 8'hF7, 8'hEF, 8'hFE, 8'hFE,
      8'h7F, 8'hFF};
   logic t_open [8] = '{0, 1, 1, 0, 0, 1, 0, 1};
   int mismatches = 0, total_checks = 0;
   bmg_bus_if bus_i ();
   always #20 pclk = ~pclk;
   always @(posedge pclk) if (bus_i.xcvr_open === 1'b1) opened <= 1'b1;
   always @(posedge pclk) if (bus_i.data_to_proc_oe === 1'b1) drove <= 1'b1;
   bmg_proc u_bmg_proc (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_i));
   bmg_board u_bmg_board (.pclk(pclk), .presetn(presetn),
      .power_on_n(power_on_n), .slow_clock_mode(slow_mode),
      .oscillator_clock_input(osc), .dram_size_code(3'h5),
      .dram_delay_70(1'b1), .control_bits(control_bits), .bus(bus_i));
   bmg_checker u_bmg_checker (.pclk(pclk), .presetn(presetn),
      .power_on_n(power_on_n), .control_bits(control_bits),
      .cs_n(bus_i.cs_n), .cfg_phase(bus_i.cfg_phase),
      .xcvr_open(bus_i.xcvr_open), .clock_mode_pins(bus_i.clock_mode_pins),
      .external_clock_input(bus_i.external_clock_input),
      .dram_bank1_select_n(bus_i.dram_bank1_select_n),
      .dram_bank2_select_n(bus_i.dram_bank2_select_n),
      .dram_addr_sel(bus_i.dram_addr_sel));
   task summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task tmo();
      mismatches++;
      summarize();
   endtask
   task chk(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One local access: pattern, data, go, wait idle, fetch data
   task acc(input logic [7:0] cs, input logic [5:0] cmd,
      input logic [7:0] wd);
      int n;
      apb(1'b1, bmg_pkg::APB_CS_PAT, {24'h0, cs});
      apb(1'b1, bmg_pkg::APB_WDATA, {24'h0, wd});
      opened = 1'b0;
      drove = 1'b0;
      apb(1'b1, bmg_pkg::APB_CMD, {26'h0, cmd});
      n = 0;
      do begin
         apb(1'b0, bmg_pkg::APB_STAT, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 40);
      if (n >= 40) tmo();
      repeat (4) @(posedge pclk);
      apb(1'b0, bmg_pkg::APB_RDATA, 32'h0);
   endtask
   task rst(input logic por);
      presetn <= 1'b0;
      power_on_n <= ~por;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      power_on_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      power_on_n <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("mode pins", bus_i.clock_mode_pins, 2'h3);
      chk("control", control_bits, bmg_pkg::CTL_RESET);
      osc <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("ext clock", bus_i.external_clock_input, 1'b1);
      apb(1'b0, bmg_pkg::APB_CS_PAT, 32'h0);
      chk("cs pattern", q, 32'hFF);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", q, 32'h0);
      acc(8'hFD, 6'h21, 8'h00);
      chk("status", q, 32'h0D);
      chk("ctrl open", opened, 1'b1);
      chk("read drive", drove, 1'b1);
      acc(8'hFD, 6'h13, 8'h14);
      chk("control", control_bits, 5'h14);
      chk("write drive", drove, 1'b0);
      chk("addr sel", bus_i.dram_addr_sel, 2'h3);
      acc(8'hFD, 6'h11, 8'h00);
      chk("control rd", q, 32'h14);
      for (int i = 0; i < 8; i++) begin
         acc(8'hFD, 6'h13, t_ctl[i]);
         acc(t_cs[i], (t_cs[i] == 8'hFF) ? 6'h05 : 6'h01, 8'h00);
         chk("opened", opened, t_open[i]);
      end
      acc(8'hFD, 6'h13, 8'h0A);
      acc(8'hFD, 6'h13, 8'h08);
      chk("removed", control_bits, 5'h0A);
      chk("removed open", opened, 1'b0);
      rst(1'b0);
      chk("after reset", control_bits, 5'h0A);
      slow_mode <= 1'b1;
      rst(1'b1);
      chk("power on", control_bits, bmg_pkg::CTL_RESET);
      chk("slow pins", bus_i.clock_mode_pins, 2'h0);
      chk("slow clock", bus_i.external_clock_input, 1'b0);
      summarize();
   end
endmodule
